/* hw/oici_pkg.sv */
// shared constants and types of the onboard I/O counter interface
package oici_pkg;

   // ==========================================================
   // peripheral byte addresses (fixed, not relocatable)
   localparam int ADDR_W = 16;
   localparam logic [15:0] ADDR_CNT1_PRESET = 16'h0112;
   localparam logic [15:0] ADDR_CNT1_CTRL   = 16'h0114;
   localparam logic [15:0] ADDR_CNT2_PRESET = 16'h0115;
   localparam logic [15:0] ADDR_CNT2_CTRL   = 16'h0117;
   localparam logic [15:0] ADDR_CNT3_PRESET = 16'h0118;
   localparam logic [15:0] ADDR_CNT3_CTRL   = 16'h011A;
   localparam logic [15:0] ADDR_CNT1_VALUE  = 16'h0118;
   localparam logic [15:0] ADDR_CNT2_VALUE  = 16'h011A;
   localparam logic [15:0] ADDR_CNT3_BYTE0  = 16'h011C;
   localparam logic [15:0] ADDR_CNT3_BYTE1  = 16'h011D;
   localparam logic [15:0] ADDR_CNT3_BYTE2  = 16'h011E;
   localparam logic [15:0] ADDR_STATE       = 16'h011F;

   // ==========================================================
   // field positions
   localparam int CTRL_EN_BIT    = 0;
   localparam int CTRL_LOAD_BIT  = 1;
   localparam int STATE_RUN_LSB  = 4;
   localparam int INFO_EOC_BIT   = 12;
   localparam int INFO_SRC_LSB   = 8;

   // ==========================================================
   // values
   localparam logic [15:0] AI_OVER_MIN     = 16'h7F00;
   localparam logic [15:0] AI_UNDER_MAX    = 16'h80FF;
   localparam logic [15:0] AI_RANGE_ERROR  = 16'h7FFF;
   localparam logic [15:0] MODULE_START    = 16'h0110;
   localparam logic [15:0] INFO_THREE_ZERO = 16'h0000;
   localparam logic [7:0]  BYTE_ZERO       = 8'h00;

   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int TICK_NS       = 1000;
   localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GATE_FAST_MS  = 100;
   localparam int GATE_MID_MS   = 1000;
   localparam int GATE_SLOW_MS  = 10000;
   localparam int TICKS_PER_MS  = 1000;

   // ==========================================================
   // types
   typedef enum logic [2:0] {
      FUNC_DIGITAL,
      FUNC_ALARM,
      FUNC_COUNTER,
      FUNC_FREQ,
      FUNC_PERIOD
   } oici_func_t;

   typedef enum logic [1:0] {
      GATE_FAST,
      GATE_MID,
      GATE_SLOW
   } oici_gate_t;

   typedef enum logic [0:0] {
      CYC_IDLE,
      CYC_RUN
   } oici_cyc_t;

endpackage

/* hw/oici_counter.sv */
// one event counter channel with preset, compare and hit detection
`timescale 1ns/1ps
`default_nettype none
module oici_counter #(
   parameter int W = 16
) (
   // clock and reset
   input  wire logic         core_clk,
   input  wire logic         rst,
   // control
   input  wire logic         active,
   input  wire logic         countDown,
   input  wire logic         countEvent,
   input  wire logic         loadPulse,
   input  wire logic [W-1:0] loadValue,
   // results
   output logic [W-1:0]      count,
   output logic              hit
);
   import oici_pkg::*;

   logic [W-1:0] count_q;
   logic [W-1:0] compare_q;
   logic         hit_q;

   // down counters start from the written value, up counters compare against it
   always_ff @(posedge core_clk) begin
      if (rst) begin
         count_q   <= '0;
         compare_q <= '0;
      end else if (loadPulse) begin
         if (countDown) begin
            count_q <= loadValue;
         end else begin
            count_q   <= '0;
            compare_q <= loadValue;
         end
      end else if (active && countEvent) begin
         count_q <= countDown ? count_q - W'(1) : count_q + W'(1);
      end
   end

   // hit on reaching compare when counting up, on the zero transition when down
   always_ff @(posedge core_clk) begin
      if (rst) begin
         hit_q <= 1'b0;
      end else begin
         hit_q <= active && countEvent && !loadPulse &&
                  (countDown ? (count_q == W'(1)) : (count_q + W'(1) == compare_q));
      end
   end

   assign count = count_q;
   assign hit   = hit_q;

endmodule
`default_nettype wire

/* hw/oici_top.sv */
// onboard I/O: universal inputs, counters, analog value handling, alarm info
// ==========================================================
`timescale 1ns/1ps
`default_nettype none
module oici_top
   import oici_pkg::*;
#(
   parameter int CW           = 16,
   parameter int FW           = 24,
   parameter int GATE_FAST_TK = GATE_FAST_MS * TICKS_PER_MS,
   parameter int GATE_MID_TK  = GATE_MID_MS * TICKS_PER_MS,
   parameter int GATE_SLOW_TK = GATE_SLOW_MS * TICKS_PER_MS
) (
   // clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   // peripheral byte access from the CPU
   input  wire logic                 wrStb,
   input  wire logic [ADDR_W-1:0]    wrAddr,
   input  wire logic [7:0]           wrData,
   input  wire logic                 rdStb,
   input  wire logic [ADDR_W-1:0]    rdAddr,
   output logic [7:0]                rdData,
   output logic                      rdValid,
   // universal input pins
   input  wire logic [3:0]           uniIn,
   // parameter block
   input  wire oici_pkg::oici_func_t funcSel1,
   input  wire oici_pkg::oici_func_t funcSel2,
   input  wire oici_pkg::oici_func_t funcSel3,
   input  wire oici_pkg::oici_func_t funcSel4,
   input  wire logic [2:0]           countDown,
   input  wire logic [3:0]           fallingEdge,
   input  wire logic [2:0]           hitAlarmEn,
   input  wire oici_pkg::oici_gate_t gateSel,
   input  wire logic                 diagEnable,
   input  wire logic                 alarmCycleMode,
   input  wire logic                 useSubstitute,
   input  wire logic [15:0]          substituteValue,
   // operating state
   input  wire logic                 cpuRun,
   input  wire logic                 supplyOk,
   // analog converter side
   input  wire logic [15:0]          adcValue,
   input  wire logic                 adcValid,
   input  wire logic                 cycleDone,
   input  wire logic                 timedAlarm,
   input  wire logic [15:0]          aoCpuValue,
   output logic [15:0]               aiValue,
   output logic [15:0]               aoValue,
   output logic                      cycleStart,
   output logic                      diagMessage,
   output logic                      diagAlarm,
   // process alarm
   output logic                      procAlarm,
   output logic [15:0]               alarmInfoWordOne,
   output logic [15:0]               alarmInfoWordTwo,
   output logic [15:0]               alarmInfoWordThree
);
   import oici_pkg::*;

   // overflow is 7F00 and up, underflow 80FF and down, signed
   function automatic logic outOfRange(input logic [15:0] v);
      return ($signed(v) >= $signed(AI_OVER_MIN)) || ($signed(v) <= $signed(AI_UNDER_MAX));
   endfunction

   // ==========================================================
   // input synchronisers and edge detection
   logic [3:0]  syncA_q, syncB_q, syncC_q, level_q, levelPrev_q;
   logic [3:0]  edgeEvent;
   oici_func_t  func [4];

   assign func[0] = funcSel1;
   assign func[1] = funcSel2;
   assign func[2] = funcSel3;
   assign func[3] = funcSel4;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         syncA_q     <= '0;
         syncB_q     <= '0;
         syncC_q     <= '0;
         level_q     <= '0;
         levelPrev_q <= '0;
      end else begin
         syncA_q     <= uniIn;
         syncB_q     <= syncA_q;
         syncC_q     <= syncB_q;
         level_q     <= (syncB_q & syncC_q) | (level_q & (syncB_q ^ syncC_q));
         levelPrev_q <= level_q;
      end
   end

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         edgeEvent[i] = fallingEdge[i] ? (levelPrev_q[i] & ~level_q[i]) : (level_q[i] & ~levelPrev_q[i]);
      end
   end

   // ==========================================================
   // preset words and control bytes, high byte at the lower address
   logic [15:0] preset_q [3];
   logic [2:0]  enable_q, loadPulse_q;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int i = 0; i < 3; i++) begin
            preset_q[i] <= '0;
         end
      end else if (wrStb) begin
         unique case (wrAddr)
            ADDR_CNT1_PRESET:         preset_q[0][15:8] <= wrData;
            ADDR_CNT1_PRESET + 16'h1: preset_q[0][7:0]  <= wrData;
            ADDR_CNT2_PRESET:         preset_q[1][15:8] <= wrData;
            ADDR_CNT2_PRESET + 16'h1: preset_q[1][7:0]  <= wrData;
            ADDR_CNT3_PRESET:         preset_q[2][15:8] <= wrData;
            ADDR_CNT3_PRESET + 16'h1: preset_q[2][7:0]  <= wrData;
            default: ;
         endcase
      end
   end

   // a control write with the load bit at zero marks the new value invalid: no load
   always_ff @(posedge core_clk) begin
      if (rst) begin
         enable_q    <= '0;
         loadPulse_q <= '0;
      end else begin
         loadPulse_q <= '0;
         if (wrStb) begin
            unique case (wrAddr)
               ADDR_CNT1_CTRL: begin
                  enable_q[0]    <= wrData[CTRL_EN_BIT];
                  loadPulse_q[0] <= wrData[CTRL_LOAD_BIT];
               end
               ADDR_CNT2_CTRL: begin
                  enable_q[1]    <= wrData[CTRL_EN_BIT];
                  loadPulse_q[1] <= wrData[CTRL_LOAD_BIT];
               end
               ADDR_CNT3_CTRL: begin
                  enable_q[2]    <= wrData[CTRL_EN_BIT];
                  loadPulse_q[2] <= wrData[CTRL_LOAD_BIT];
               end
               default: ;
            endcase
         end
      end
   end

   // ==========================================================
   // event counters 1 to 3
   logic [CW-1:0] cntValue [3];
   logic [2:0]    cntHit, cntActive;

   for (genvar g = 0; g < 3; g++) begin : gCnt
      assign cntActive[g] = enable_q[g] && (func[g] == FUNC_COUNTER);
      oici_counter #(.W(CW)) uCnt (
         .core_clk   (core_clk),
         .rst        (rst),
         .active     (cntActive[g]),
         .countDown  (countDown[g]),
         .countEvent (edgeEvent[g]),
         .loadPulse  (loadPulse_q[g]),
         .loadValue  (CW'(preset_q[g])),
         .count      (cntValue[g]),
         .hit        (cntHit[g])
      );
   end

   // ==========================================================
   // frequency and period measurement on input 3, microsecond timebase
   localparam int TW = $clog2(TICK_CYCLES + 1);
   logic [TW-1:0] tickDiv_q;
   logic          tick_q;
   logic [FW-1:0] gateCnt_q, measAcc_q, measResult_q;
   logic [FW-1:0] gateLen;
   logic          measFreq, measPeriod;

   assign measFreq   = (func[2] == FUNC_FREQ);
   assign measPeriod = (func[2] == FUNC_PERIOD);

   always_comb begin
      unique case (gateSel)
         GATE_FAST: gateLen = FW'(GATE_FAST_TK);
         GATE_MID:  gateLen = FW'(GATE_MID_TK);
         GATE_SLOW: gateLen = FW'(GATE_SLOW_TK);
         default:   gateLen = FW'(GATE_MID_TK);
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         tickDiv_q <= '0;
         tick_q    <= 1'b0;
      end else begin
         tick_q    <= (tickDiv_q == TW'(TICK_CYCLES - 1));
         tickDiv_q <= (tickDiv_q == TW'(TICK_CYCLES - 1)) ? '0 : tickDiv_q + TW'(1);
      end
   end

   // accumulators saturate rather than wrap so an overlong period reads full scale at its closing edge
   always_ff @(posedge core_clk) begin
      if (rst || !(measFreq || measPeriod)) begin
         gateCnt_q    <= '0;
         measAcc_q    <= '0;
         measResult_q <= '0;
      end else if (measFreq) begin
         if (tick_q) begin
            gateCnt_q <= (gateCnt_q + FW'(1) >= gateLen) ? '0 : gateCnt_q + FW'(1);
         end
         if (tick_q && (gateCnt_q + FW'(1) >= gateLen)) begin
            measResult_q <= measAcc_q;
            measAcc_q    <= FW'(edgeEvent[2]);
         end else if (edgeEvent[2] && (measAcc_q != '1)) begin
            measAcc_q <= measAcc_q + FW'(1);
         end
      end else begin
         if (edgeEvent[2]) begin
            measResult_q <= measAcc_q;
            measAcc_q    <= '0;
         end else if (tick_q && (measAcc_q != '1)) begin
            measAcc_q <= measAcc_q + FW'(1);
         end
      end
   end

   // ==========================================================
   // CPU reads, answered one cycle after the strobe
   logic [FW-1:0] thirdWord;
   logic [7:0]    stateByte;
   logic [7:0]    rdData_q;
   logic          rdValid_q;

   assign thirdWord = (measFreq || measPeriod) ? measResult_q : FW'(cntValue[2]);
   assign stateByte = {1'b0, cntActive, level_q};

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdData_q  <= BYTE_ZERO;
         rdValid_q <= 1'b0;
      end else begin
         rdValid_q <= rdStb;
         if (rdStb) begin
            unique case (rdAddr)
               ADDR_CNT1_VALUE:         rdData_q <= cntValue[0][15:8];
               ADDR_CNT1_VALUE + 16'h1: rdData_q <= cntValue[0][7:0];
               ADDR_CNT2_VALUE:         rdData_q <= cntValue[1][15:8];
               ADDR_CNT2_VALUE + 16'h1: rdData_q <= cntValue[1][7:0];
               ADDR_CNT3_BYTE0:         rdData_q <= thirdWord[23:16];
               ADDR_CNT3_BYTE1:         rdData_q <= thirdWord[15:8];
               ADDR_CNT3_BYTE2:         rdData_q <= thirdWord[7:0];
               ADDR_STATE:              rdData_q <= stateByte;
               default:                 rdData_q <= BYTE_ZERO;
            endcase
         end
      end
   end

   assign rdData  = rdData_q;
   assign rdValid = rdValid_q;

   // ==========================================================
   // analog input and output values
   logic [15:0] aiValue_q, aoValue_q;
   logic        diagMsg_q, diagAlarm_q;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         aiValue_q   <= '0;
         diagMsg_q   <= 1'b0;
         diagAlarm_q <= 1'b0;
      end else begin
         diagMsg_q   <= 1'b0;
         diagAlarm_q <= 1'b0;
         if (adcValid && supplyOk) begin
            aiValue_q <= outOfRange(adcValue) ? AI_RANGE_ERROR : adcValue;
            if (outOfRange(adcValue) && diagEnable) begin
               diagMsg_q   <= 1'b1;
               diagAlarm_q <= 1'b1;
            end
         end
      end
   end

   // loss of supply drives zero, stop drives substitute or holds
   always_ff @(posedge core_clk) begin
      if (rst || !supplyOk) begin
         aoValue_q <= '0;
      end else if (cpuRun) begin
         aoValue_q <= outOfRange(aoCpuValue) ? '0 : aoCpuValue;
      end else if (useSubstitute) begin
         aoValue_q <= substituteValue;
      end
   end

   assign aiValue     = aiValue_q;
   assign aoValue     = aoValue_q;
   assign diagMessage = diagMsg_q;
   assign diagAlarm   = diagAlarm_q;

   // ==========================================================
   // measuring cycle sequencing
   oici_cyc_t cyc_q;
   logic      cycleStart_q, endOfCycle_q;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cyc_q        <= CYC_IDLE;
         cycleStart_q <= 1'b0;
         endOfCycle_q <= 1'b0;
      end else begin
         cycleStart_q <= 1'b0;
         endOfCycle_q <= 1'b0;
         unique case (cyc_q)
            CYC_IDLE: if (!alarmCycleMode || timedAlarm) begin
               cycleStart_q <= 1'b1;
               cyc_q        <= CYC_RUN;
            end
            CYC_RUN: if (cycleDone) begin
               endOfCycle_q <= alarmCycleMode;
               cyc_q        <= CYC_IDLE;
            end
         endcase
      end
   end

   assign cycleStart = cycleStart_q;

   // ==========================================================
   // process alarm and its information words
   logic [3:0]  alarmSrc;
   logic        procAlarm_q;
   logic [15:0] infoTwo_q;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         alarmSrc[i] = (func[i] == FUNC_ALARM) && edgeEvent[i];
      end
      for (int i = 0; i < 3; i++) begin
         alarmSrc[i] = alarmSrc[i] || (cntHit[i] && hitAlarmEn[i] && cntActive[i]);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         procAlarm_q <= 1'b0;
         infoTwo_q   <= '0;
      end else begin
         procAlarm_q <= (|alarmSrc) || endOfCycle_q;
         if ((|alarmSrc) || endOfCycle_q) begin
            infoTwo_q                             <= '0;
            infoTwo_q[INFO_SRC_LSB +: 4]          <= alarmSrc;
            infoTwo_q[INFO_EOC_BIT]               <= endOfCycle_q;
         end
      end
   end

   assign procAlarm          = procAlarm_q;
   assign alarmInfoWordOne   = MODULE_START;
   assign alarmInfoWordTwo   = infoTwo_q;
   assign alarmInfoWordThree = INFO_THREE_ZERO;

   // ==========================================================
   // checks
   load_takes_preset_a: assert property (@(posedge core_clk) disable iff (rst)
      loadPulse_q[0] && countDown[0] |=> cntValue[0] == $past(preset_q[0]))
      else $error("down counter did not take preset");

   ctrl_load_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
      wrStb && wrAddr == ADDR_CNT1_CTRL && !wrData[CTRL_LOAD_BIT] |=> !loadPulse_q[0])
      else $error("load taken with invalid flag");

   ctrl_enable_a: assert property (@(posedge core_clk) disable iff (rst)
      wrStb && wrAddr == ADDR_CNT2_CTRL |=> enable_q[1] == $past(wrData[CTRL_EN_BIT]))
      else $error("enable bit not stored");

   state_byte_a: assert property (@(posedge core_clk) disable iff (rst)
      rdStb && rdAddr == ADDR_STATE |=> rdValid && rdData[STATE_RUN_LSB +: 3] == $past(cntActive))
      else $error("counting state bits wrong");

   ai_range_a: assert property (@(posedge core_clk) disable iff (rst)
      adcValid && supplyOk && outOfRange(adcValue) |=> aiValue == AI_RANGE_ERROR)
      else $error("range error code not reported");

   diag_gate_a: assert property (@(posedge core_clk) disable iff (rst)
      !$past(diagEnable) |-> !diagMessage && !diagAlarm)
      else $error("diagnostic without enable");

   ao_range_a: assert property (@(posedge core_clk) disable iff (rst)
      supplyOk && cpuRun && outOfRange(aoCpuValue) |=> aoValue == 16'h0000)
      else $error("output out of range not zeroed");

   cycle_wait_a: assert property (@(posedge core_clk) disable iff (rst)
      cyc_q == CYC_IDLE && alarmCycleMode && !timedAlarm |=> !cycleStart)
      else $error("cycle started without timed alarm");

   eoc_info_a: assert property (@(posedge core_clk) disable iff (rst)
      endOfCycle_q |=> procAlarm && alarmInfoWordTwo[INFO_EOC_BIT])
      else $error("end of cycle not flagged");

endmodule
`default_nettype wire

/* testbench/oici_cpu_model.sv */
// CPU side model: byte writes and reads on the peripheral port
`timescale 1ns/1ps
`default_nettype none
module oici_cpu_model (
   // clock
   input  wire logic       core_clk,
   // peripheral byte access
   output logic            wrStb,
   output logic [15:0]     wrAddr,
   output logic [7:0]      wrData,
   output logic            rdStb,
   output logic [15:0]     rdAddr,
   input  wire logic [7:0] rdData,
   input  wire logic       rdValid
);
   initial begin
      {wrStb, rdStb} = 2'b00;
      {wrAddr, rdAddr, wrData} = '0;
   end
   // idle lines are turned over so a stale value never reads as a match
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #1;
      wrStb = 1'b1;
      wrAddr = a;
      wrData = d;
      @(posedge core_clk);
      #1;
      wrStb = 1'b0;
      wrAddr = ~a;
      wrData = ~d;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge core_clk);
      #1;
      rdStb = 1'b1;
      rdAddr = a;
      @(posedge core_clk);
      #1;
      rdStb = 1'b0;
      rdAddr = ~a;
      d = (rdValid === 1'b1) ? rdData : 8'hXX;
   endtask
endmodule
`default_nettype wire

/* testbench/onboard_io_counter_interface_tb.sv */
// self-checking bench of the onboard I/O counter interface
`timescale 1ns/1ps
`default_nettype none
module onboard_io_counter_interface_tb;
   import oici_pkg::*;
   // ==========================================================
   // signals
   logic core_clk, rst, wrStb, rdStb, rdValid, supplyOk, cpuRun, adcValid, cycleDone, timedAlarm;
   logic diagEnable, alarmCycleMode, useSubstitute, cycleStart, diagMessage, diagAlarm, procAlarm;
   logic [15:0] wrAddr, rdAddr, substituteValue, adcValue, aoCpuValue, aiValue, aoValue, w;
   logic [15:0] alarmInfoWordOne, alarmInfoWordTwo, alarmInfoWordThree;
   logic [7:0]  wrData, rdData, b;
   logic [3:0]  uniIn, fallingEdge;
   logic [2:0]  countDown, hitAlarmEn;
   oici_func_t  funcSel1, funcSel2, funcSel3, funcSel4;
   oici_gate_t  gateSel;
   int          error_cnt, n_compared, cyc_n, alarm_n;
   oici_top #(.GATE_FAST_TK(10), .GATE_MID_TK(20), .GATE_SLOW_TK(40)) dut_u (
      .core_clk, .rst, .wrStb, .wrAddr, .wrData, .rdStb, .rdAddr, .rdData, .rdValid, .uniIn,
      .funcSel1, .funcSel2, .funcSel3, .funcSel4, .countDown, .fallingEdge, .hitAlarmEn, .gateSel,
      .diagEnable, .alarmCycleMode, .useSubstitute, .substituteValue, .cpuRun, .supplyOk,
      .adcValue, .adcValid, .cycleDone, .timedAlarm, .aoCpuValue, .aiValue, .aoValue, .cycleStart,
      .diagMessage, .diagAlarm, .procAlarm, .alarmInfoWordOne, .alarmInfoWordTwo, .alarmInfoWordThree);
   oici_cpu_model cpu_u (.core_clk, .wrStb, .wrAddr, .wrData, .rdStb, .rdAddr, .rdData, .rdValid);
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // edges since time zero, and process alarm pulses seen while they stand
   always @(posedge core_clk) begin
      cyc_n <= cyc_n + 1;
      if (procAlarm === 1'b1) alarm_n <= alarm_n + 1;
   end
   // ==========================================================
   // helpers
   task automatic stop_test();
      $display("compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // words are big-endian: high byte at the lower address
   task automatic rdw(input logic [15:0] a);
      cpu_u.rd(a, w[15:8]);
      cpu_u.rd(a + 16'h0001, w[7:0]);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_reset();
      rdw(16'h0118);
      chk("count1 after reset", 16'h0000, w);
      chk("info one", 16'h0110, alarmInfoWordOne);
      chk("info three", 16'h0000, alarmInfoWordThree);
   endtask
   task automatic t_counter();
      funcSel1 = FUNC_COUNTER;
      funcSel2 = FUNC_COUNTER;
      countDown = 3'b001;
      cpu_u.wr(16'h0112, 8'h00);
      cpu_u.wr(16'h0113, 8'h03);
      cpu_u.wr(16'h0114, 8'h03);
      rdw(16'h0118);
      chk("count1 preset", 16'h0003, w);
      uniIn[0] = 1'b1;
      cyc(8);
      cpu_u.rd(16'h011F, b);
      chk("state running", 16'h0011, {8'h00, b});
      uniIn[0] = 1'b0;
      cyc(8);
      rdw(16'h0118);
      chk("count1 after edge", 16'h0002, w);
      cpu_u.wr(16'h0113, 8'h09);
      cpu_u.wr(16'h0114, 8'h01);
      rdw(16'h0118);
      chk("count1 no load", 16'h0002, w);
      cpu_u.wr(16'h0114, 8'h00);
      cpu_u.rd(16'h011F, b);
      chk("state stopped", 16'h0000, {8'h00, b});
   endtask
   task automatic pulse(input int i);
      uniIn[i] = 1'b1;
      cyc(8);
      uniIn[i] = 1'b0;
      cyc(8);
   endtask
   task automatic t_events();
      int a;
      a = alarm_n;
      hitAlarmEn = 3'b010;
      cpu_u.wr(16'h0116, 8'h02);
      cpu_u.wr(16'h0117, 8'h03);
      pulse(1);
      pulse(1);
      rdw(16'h011A);
      chk("count2 up", 16'h0002, w);
      chk("hit alarm", 16'(a + 1), 16'(alarm_n));
      chk("info two hit", 16'h0200, alarmInfoWordTwo);
      cpu_u.rd(16'h011F, b);
      chk("state counter2", 16'h0020, {8'h00, b});
      fallingEdge = 4'b1000;
      pulse(3);
      chk("input alarm", 16'(a + 2), 16'(alarm_n));
      chk("info two input", 16'h0800, alarmInfoWordTwo);
      // start half a tick off the timebase so no edge shares a cycle with a tick
      funcSel3 = FUNC_PERIOD;
      while (cyc_n % TICK_CYCLES != TICK_CYCLES / 2) cyc(1);
      uniIn[2] = 1'b1;
      cyc(TICK_CYCLES * 5 / 2);
      uniIn[2] = 1'b0;
      cyc(TICK_CYCLES * 5 / 2);
      uniIn[2] = 1'b1;
      cyc(8);
      cpu_u.rd(16'h011C, b);
      chk("period top byte", 16'h0000, {8'h00, b});
      rdw(16'h011D);
      chk("period five ticks", 16'h0005, w);
      uniIn[2] = 1'b0;
   endtask
   task automatic ai(input logic [15:0] v, input logic [15:0] e, input logic [1:0] dg);
      adcValue = v;
      adcValid = 1'b1;
      cyc(1);
      adcValid = 1'b0;
      chk("analog in", e, aiValue);
      chk("diag pulses", {14'h0000, dg}, {14'h0000, diagMessage, diagAlarm});
      cyc(1);
   endtask
   task automatic ao(input logic [15:0] v, input logic [15:0] e);
      aoCpuValue = v;
      cyc(2);
      chk("analog out", e, aoValue);
   endtask
   task automatic t_analog();
      ai(16'h6C00, 16'h6C00, 2'b00);
      ai(16'h8100, 16'h8100, 2'b00);
      ai(16'h7F00, 16'h7FFF, 2'b11);
      ai(16'h80FF, 16'h7FFF, 2'b11);
      diagEnable = 1'b0;
      ai(16'h7F00, 16'h7FFF, 2'b00);
      ao(16'h7EFF, 16'h7EFF);
      ao(16'h7F00, 16'h0000);
      cpuRun = 1'b0;
      useSubstitute = 1'b1;
      substituteValue = 16'h0055;
      ao(16'h1234, 16'h0055);
      useSubstitute = 1'b0;
      ao(16'h0777, 16'h0055);
      supplyOk = 1'b0;
      ao(16'h0777, 16'h0000);
   endtask
   task automatic t_cycle();
      int a;
      a = alarm_n;
      alarmCycleMode = 1'b1;
      cycleDone = 1'b1;
      cyc(1);
      cycleDone = 1'b0;
      cyc(4);
      chk("info two end", 16'h1000, alarmInfoWordTwo & 16'h1000);
      chk("end alarm", 16'(a + 1), 16'(alarm_n));
      repeat (6) begin
         cyc(1);
         chk("no new cycle", 16'h0000, {15'h0000, cycleStart});
      end
      timedAlarm = 1'b1;
      cyc(1);
      timedAlarm = 1'b0;
      b = 8'h00;
      repeat (3) begin
         if (cycleStart === 1'b1) b = 8'h01;
         cyc(1);
      end
      chk("cycle after alarm", 16'h0001, {8'h00, b});
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial begin
      {error_cnt, n_compared} = '0;
      rst = 1'b1;
      {adcValid, cycleDone, timedAlarm, alarmCycleMode, useSubstitute} = '0;
      {uniIn, fallingEdge, countDown, hitAlarmEn} = '0;
      {adcValue, aoCpuValue, substituteValue} = '0;
      {supplyOk, cpuRun, diagEnable} = 3'b111;
      funcSel1 = FUNC_DIGITAL;
      funcSel2 = FUNC_DIGITAL;
      funcSel3 = FUNC_DIGITAL;
      funcSel4 = FUNC_ALARM;
      gateSel = GATE_FAST;
      cyc(8);
      rst = 1'b0;
      t_reset();
      t_counter();
      t_events();
      t_analog();
      t_cycle();
      stop_test();
   end
   initial begin
      #50000;
      error_cnt++;
      stop_test();
   end
endmodule
`default_nettype wire
